// File: logic/ascf_top.sv
// Alarm, status indicator and serial command framing logic
`default_nettype none
module ascf_top
  import ascf_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        arst_n_in,
  // Measurements
  input  wire logic [15:0] conc_in,
  input  wire logic        conc_neg_in,
  input  wire logic        over_range_in,
  input  wire logic [12:0] ref_mv_in,
  input  wire logic [12:0] meas_mv_in,
  input  wire logic [11:0] press_cpsi_in,
  // Alarm configuration
  input  wire logic        low_latch_in,
  input  wire logic        high_latch_in,
  input  wire logic        cfg_we_in,
  input  wire logic [15:0] low_limit_in,
  input  wire logic [15:0] high_limit_in,
  input  wire logic        panel_clear_key_in,
  // Serial receive byte stream
  input  wire logic        rx_valid_in,
  input  wire logic [7:0]  rx_data_in,
  // Serial transmit byte stream
  input  wire logic        tx_ready_in,
  output logic             tx_valid_out,
  output logic [7:0]       tx_data_out,
  output logic             tx_drive_en_out,
  // Indicators and digital status outputs
  output logic             sensor_ok_led_out,
  output logic             invalid_led_out,
  output logic             lamp_low_led_out,
  output logic             alarm_led_out,
  output logic             first_alarm_board_indicator_out,
  output logic             second_alarm_board_indicator_out,
  output logic [3:0]       status_dout_out
);
  // Decimal digit test used by the parser
  function automatic logic is_digit(input logic [7:0] c);
    is_digit = (c >= CH_ZERO) && (c <= CH_NINE);
  endfunction

  // Configuration state
  logic [15:0] low_limit_r, low_limit_nxt, high_limit_r, high_limit_nxt;
  logic        low_latch_r, low_latch_nxt, high_latch_r, high_latch_nxt;
  logic [3:0]  addr_r;
  logic        first_level_alarm, second_level_alarm;
  logic        clear_req;
  logic        alarm_clear_command;

  // Limit and mode registers load on a configuration strobe
  always_comb begin
    low_limit_nxt  = low_limit_r;
    high_limit_nxt = high_limit_r;
    low_latch_nxt  = low_latch_r;
    high_latch_nxt = high_latch_r;
    if (cfg_we_in) begin
      low_limit_nxt  = low_limit_in;
      high_limit_nxt = high_limit_in;
      low_latch_nxt  = low_latch_in;
      high_latch_nxt = high_latch_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      low_limit_r  <= LOW_LIMIT_RST;
      high_limit_r <= HIGH_LIMIT_RST;
      low_latch_r  <= 1'b1;
      high_latch_r <= 1'b1;
      addr_r       <= ADDR_RST;
    end else begin
      low_limit_r  <= low_limit_nxt;
      high_limit_r <= high_limit_nxt;
      low_latch_r  <= low_latch_nxt;
      high_latch_r <= high_latch_nxt;
      addr_r       <= addr_r;
    end
  end

  // Key and serial command share one clear request
  assign clear_req = panel_clear_key_in || alarm_clear_command;

  ascf_alarm u_low (
    .core_clk_in  (core_clk_in),
    .arst_n_in    (arst_n_in),
    .latch_mode_in(low_latch_r),
    .limit_in     (low_limit_r),
    .conc_in      (conc_in),
    .conc_neg_in  (conc_neg_in),
    .clear_req_in (clear_req),
    .active_out   (first_level_alarm)
  );

  ascf_alarm u_high (
    .core_clk_in  (core_clk_in),
    .arst_n_in    (arst_n_in),
    .latch_mode_in(high_latch_r),
    .limit_in     (high_limit_r),
    .conc_in      (conc_in),
    .conc_neg_in  (conc_neg_in),
    .clear_req_in (clear_req),
    .active_out   (second_level_alarm)
  );

  // Blink timer and indicator registers
  logic [23:0] blink_cnt_r, blink_cnt_nxt;
  logic        blink_r, blink_nxt;
  logic        sok_nxt, inv_nxt, lamp_nxt, alm_nxt;

  always_comb begin
    blink_cnt_nxt = blink_cnt_r + 24'h000001;
    blink_nxt     = blink_r;
    if (blink_cnt_r == 24'(BLINK_CYC - 1)) begin
      blink_cnt_nxt = 24'h000000;
      blink_nxt     = !blink_r;
    end
    sok_nxt  = !((ref_mv_in > SENSOR_MAX_MV) || (meas_mv_in > SENSOR_MAX_MV)
                 || (ref_mv_in < REF_LO_MV));
    inv_nxt  = (press_cpsi_in > PRESS_MAX_CPSI) || conc_neg_in || over_range_in;
    lamp_nxt = ref_mv_in < LAMP_LO_MV;
    alm_nxt  = (first_level_alarm || second_level_alarm) && blink_r;
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      blink_cnt_r                      <= 24'h000000;
      blink_r                          <= 1'b0;
      sensor_ok_led_out                <= 1'b0;
      invalid_led_out                  <= 1'b0;
      lamp_low_led_out                 <= 1'b0;
      alarm_led_out                    <= 1'b0;
      first_alarm_board_indicator_out  <= 1'b0;
      second_alarm_board_indicator_out <= 1'b0;
      status_dout_out                  <= 4'h0;
    end else begin
      blink_cnt_r                      <= blink_cnt_nxt;
      blink_r                          <= blink_nxt;
      sensor_ok_led_out                <= sok_nxt;
      invalid_led_out                  <= inv_nxt;
      lamp_low_led_out                 <= lamp_nxt;
      alarm_led_out                    <= alm_nxt;
      first_alarm_board_indicator_out  <= first_level_alarm;
      second_alarm_board_indicator_out <= second_level_alarm;
      status_dout_out                  <= {alm_nxt, lamp_nxt, inv_nxt, sok_nxt};
    end
  end

  // Receive parser state
  ascf_rx_type rx_st_r, rx_st_nxt;
  logic [7:0]  cmd_buf_r [CMD_MAX];
  logic [7:0]  cmd_buf_nxt [CMD_MAX];
  logic [3:0]  cmd_len_r, cmd_len_nxt;
  logic [15:0] sum_r, sum_nxt, rx_sum_r, rx_sum_nxt;
  logic        has_sum_r, has_sum_nxt;
  logic        cmd_ok;
  ascf_cmd_type exec_cmd;
  logic        busy_r;

  // Match the command text against the two known strings
  function automatic ascf_cmd_type decode(input logic [7:0] b [CMD_MAX],
                                          input logic [3:0] n);
    decode = ASCF_CMD_NONE;
    if (n == 4'h6 && {b[0], b[1], b[2], b[3], b[4], b[5]} == {"ALM", "ACK"}) begin
      decode = ASCF_CMD_CLEAR;
    end else if (n == 4'h7 && {b[0], b[1], b[2], b[3], b[4], b[5], b[6]} == {"ALM", "STAT"}) begin
      decode = ASCF_CMD_QUERY;
    end
  endfunction

  always_comb begin
    rx_st_nxt   = rx_st_r;
    cmd_buf_nxt = cmd_buf_r;
    cmd_len_nxt = cmd_len_r;
    sum_nxt     = sum_r;
    rx_sum_nxt  = rx_sum_r;
    has_sum_nxt = has_sum_r;
    exec_cmd    = ASCF_CMD_NONE;
    cmd_ok      = 1'b0;
    if (rx_valid_in && !busy_r) begin
      if (rx_data_in == CH_CR) begin
        cmd_ok = (rx_st_r != ASCF_RX_SKIP) && (rx_st_r != ASCF_RX_ADDR)
                 && (!has_sum_r || rx_sum_r == sum_r);
        if (cmd_ok) begin
          exec_cmd = decode(cmd_buf_r, cmd_len_r);
        end
        rx_st_nxt   = ASCF_RX_ADDR;
        cmd_len_nxt = 4'h0;
        sum_nxt     = 16'h0000;
        rx_sum_nxt  = 16'h0000;
        has_sum_nxt = 1'b0;
      end else begin
        if (rx_st_r != ASCF_RX_SUM) begin
          sum_nxt = sum_r + {8'h00, rx_data_in};
        end
        case (rx_st_r)
          ASCF_RX_ADDR: begin
            rx_st_nxt = (is_digit(rx_data_in) && rx_data_in[3:0] == addr_r)
                        ? ASCF_RX_CMD : ASCF_RX_SKIP;
          end
          ASCF_RX_CMD: begin
            if (rx_data_in == CH_COLON) begin
              rx_st_nxt = ASCF_RX_DATA;
            end else if (rx_data_in == CH_HASH) begin
              rx_st_nxt   = ASCF_RX_SUM;
              has_sum_nxt = 1'b1;
              sum_nxt     = sum_r;
            end else if (cmd_len_r < 4'(CMD_MAX)) begin
              cmd_buf_nxt[cmd_len_r[2:0]] = rx_data_in;
              cmd_len_nxt                 = cmd_len_r + 4'h1;
            end else begin
              cmd_len_nxt = 4'hf;  // Overlong name matches nothing
            end
          end
          ASCF_RX_DATA: begin
            if (rx_data_in == CH_HASH) begin
              rx_st_nxt   = ASCF_RX_SUM;
              has_sum_nxt = 1'b1;
              sum_nxt     = sum_r;
            end
          end
          ASCF_RX_SUM: begin
            if (is_digit(rx_data_in)) begin
              rx_sum_nxt = 16'(rx_sum_r * 16'd10) + {12'h000, rx_data_in[3:0]};
            end else begin
              rx_st_nxt = ASCF_RX_SKIP;
            end
          end
          default: begin
            rx_st_nxt = rx_st_r;
          end
        endcase
      end
    end
  end

  assign alarm_clear_command = (exec_cmd == ASCF_CMD_CLEAR);

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_st_r   <= ASCF_RX_ADDR;
      cmd_len_r <= 4'h0;
      sum_r     <= 16'h0000;
      rx_sum_r  <= 16'h0000;
      has_sum_r <= 1'b0;
      for (int i = 0; i < CMD_MAX; i++) begin
        cmd_buf_r[i] <= 8'h00;
      end
    end else begin
      rx_st_r   <= rx_st_nxt;
      cmd_len_r <= cmd_len_nxt;
      sum_r     <= sum_nxt;
      rx_sum_r  <= rx_sum_nxt;
      has_sum_r <= has_sum_nxt;
      cmd_buf_r <= cmd_buf_nxt;
    end
  end

  // Response builder: text, then hash, decimal checksum, CR
  logic [7:0]  rsp_r [RSP_MAX];
  logic [7:0]  rsp_nxt [RSP_MAX];
  logic [4:0]  rsp_len_r, rsp_len_nxt, rsp_idx_r, rsp_idx_nxt;
  logic        busy_nxt, tx_valid_nxt;
  logic [7:0]  tx_data_nxt;
  logic [15:0] csum;
  logic [7:0]  a_ch, lo_ch, up_ch;

  always_comb begin
    rsp_nxt      = rsp_r;
    rsp_len_nxt  = rsp_len_r;
    rsp_idx_nxt  = rsp_idx_r;
    busy_nxt     = busy_r;
    tx_valid_nxt = tx_valid_out;
    tx_data_nxt  = tx_data_out;
    a_ch  = CH_ZERO | {4'h0, addr_r};
    lo_ch = CH_ZERO | {7'h00, first_level_alarm};
    up_ch = CH_ZERO | {7'h00, second_level_alarm};
    csum  = 16'h0000;
    if (exec_cmd != ASCF_CMD_NONE) begin
      if (exec_cmd == ASCF_CMD_QUERY) begin
        csum = {8'h00, a_ch} + {8'h00, CH_COLON} + {8'h00, lo_ch}
               + {8'h00, CH_COMMA} + {8'h00, up_ch};
        rsp_nxt[0] = a_ch;
        rsp_nxt[1] = CH_COLON;
        rsp_nxt[2] = lo_ch;
        rsp_nxt[3] = CH_COMMA;
        rsp_nxt[4] = up_ch;
        rsp_len_nxt = 5'h05;
      end else begin
        csum = {8'h00, a_ch} + {8'h00, CH_COLON} + {8'h00, CH_O} + {8'h00, CH_K};
        rsp_nxt[0] = a_ch;
        rsp_nxt[1] = CH_COLON;
        rsp_nxt[2] = CH_O;
        rsp_nxt[3] = CH_K;
        rsp_len_nxt = 5'h04;
      end
      // Checksum in three decimal digits, max 5 chars of 0x7f
      rsp_nxt[rsp_len_nxt[3:0]]        = CH_HASH;
      rsp_nxt[rsp_len_nxt[3:0] + 4'h1] = CH_ZERO | 8'(csum / 16'd100);
      rsp_nxt[rsp_len_nxt[3:0] + 4'h2] = CH_ZERO | 8'((csum / 16'd10) % 16'd10);
      rsp_nxt[rsp_len_nxt[3:0] + 4'h3] = CH_ZERO | 8'(csum % 16'd10);
      rsp_nxt[rsp_len_nxt[3:0] + 4'h4] = CH_CR;
      rsp_len_nxt  = rsp_len_nxt + 5'h05;
      rsp_idx_nxt  = 5'h00;
      busy_nxt     = 1'b1;
      tx_valid_nxt = 1'b0;
    end else if (busy_r) begin
      if (!tx_valid_out || tx_ready_in) begin
        if (rsp_idx_r == rsp_len_r) begin
          tx_valid_nxt = 1'b0;
          busy_nxt     = 1'b0;
        end else begin
          tx_valid_nxt = 1'b1;
          tx_data_nxt  = rsp_r[rsp_idx_r[3:0]];
          rsp_idx_nxt  = rsp_idx_r + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rsp_len_r       <= 5'h00;
      rsp_idx_r       <= 5'h00;
      busy_r          <= 1'b0;
      tx_valid_out    <= 1'b0;
      tx_data_out     <= 8'h00;
      tx_drive_en_out <= 1'b0;
      for (int i = 0; i < RSP_MAX; i++) begin
        rsp_r[i] <= 8'h00;
      end
    end else begin
      rsp_r           <= rsp_nxt;
      rsp_len_r       <= rsp_len_nxt;
      rsp_idx_r       <= rsp_idx_nxt;
      busy_r          <= busy_nxt;
      tx_valid_out    <= tx_valid_nxt;
      tx_data_out     <= tx_data_nxt;
      tx_drive_en_out <= busy_nxt;
    end
  end
endmodule
`default_nettype wire

// File: logic/ascf_pkg.sv
// Package with constants and types for the alarm status command frontend
// Summary of operation
// - Two alarms trigger at concentration >= limit
// - Any-alarm indicator blinks while an alarm active
// - Board indicator per alarm follows its state
// - Per-alarm latch mode and limit set independently
// - Non-latching alarm clears itself below limit
// - Latching alarm holds until clear request
// - Panel clear key requests clear of alarms
// - Serial clear command requests the same clear
// - Clear drops only alarms whose condition ended
// - Reset: latching, limits 100 and 300 ppb
// - Sensor-ok off on detector voltage out of window
// - Invalid-reading on pressure, negative, over-range
// - Digital status outputs mirror the four indicators
// - All characters ASCII, numbers decimal text
// - Command address defaults to one
// - Checksum is decimal sum of preceding codes
// - Commands without checksum are valid
// - Commands and responses end with CR
// - Half-duplex on multi-drop link
// - Response: address, colon, data, hash, checksum, CR
// - Alarm query reports lower then upper, 0/1
`default_nettype none
package ascf_pkg;
  localparam int          CLK_HZ         = 25_000_000;
  localparam int          BLINK_MS       = 250;
  localparam int          BLINK_CYC      = CLK_HZ / 1000 * BLINK_MS;
  localparam logic [15:0] LOW_LIMIT_RST  = 16'h0064;  // 100 ppb
  localparam logic [15:0] HIGH_LIMIT_RST = 16'h012c;  // 300 ppb
  localparam logic [12:0] SENSOR_MAX_MV  = 13'h1383;  // 4995 mV
  localparam logic [12:0] REF_LO_MV      = 13'h03e8;  // 1000 mV
  localparam logic [12:0] LAMP_LO_MV     = 13'h09c4;  // 2500 mV
  localparam logic [11:0] PRESS_MAX_CPSI = 12'h5d2;   // 14.9 psia in 0.01 psi
  localparam logic [3:0]  ADDR_RST       = 4'h1;
  localparam logic [7:0]  CH_CR          = 8'h0d;
  localparam logic [7:0]  CH_COLON       = 8'h3a;
  localparam logic [7:0]  CH_HASH        = 8'h23;
  localparam logic [7:0]  CH_COMMA       = 8'h2c;
  localparam logic [7:0]  CH_ZERO        = 8'h30;
  localparam logic [7:0]  CH_NINE        = 8'h39;
  localparam logic [7:0]  CH_O           = 8'h4f;
  localparam logic [7:0]  CH_K           = 8'h4b;
  localparam int          CMD_MAX        = 8;
  localparam int          RSP_MAX        = 16;
  // Command codes recognised by the frontend
  typedef enum logic [1:0] {
    ASCF_CMD_NONE  = 2'b00,
    ASCF_CMD_CLEAR = 2'b01,
    ASCF_CMD_QUERY = 2'b10
  } ascf_cmd_type;
  // Receive parser states
  typedef enum logic [2:0] {
    ASCF_RX_ADDR = 3'b000,
    ASCF_RX_CMD  = 3'b001,
    ASCF_RX_DATA = 3'b010,
    ASCF_RX_SUM  = 3'b011,
    ASCF_RX_SKIP = 3'b100
  } ascf_rx_type;
endpackage
`default_nettype wire

// File: logic/ascf_alarm.sv
// One concentration alarm level with latching and clear handling
`default_nettype none
module ascf_alarm
  import ascf_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        arst_n_in,
  // Configuration and inputs
  input  wire logic        latch_mode_in,
  input  wire logic [15:0] limit_in,
  input  wire logic [15:0] conc_in,
  input  wire logic        conc_neg_in,
  input  wire logic        clear_req_in,
  // State
  output logic             active_out
);
  logic active_r;
  logic active_nxt;
  logic trig;

  // Trigger when reading reaches the limit
  assign trig = !conc_neg_in && (conc_in >= limit_in);

  // Next alarm state
  always_comb begin
    if (trig) begin
      active_nxt = 1'b1;
    end else if (!latch_mode_in) begin
      active_nxt = 1'b0;
    end else if (clear_req_in) begin
      active_nxt = 1'b0;
    end else begin
      active_nxt = active_r;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      active_r <= 1'b0;
    end else begin
      active_r <= active_nxt;
    end
  end

  assign active_out = active_r;
endmodule
`default_nettype wire

// File: verification/ascf_properties.sv
// Concurrent checks on the ports of the alarm status command frontend
`default_nettype none
module ascf_properties
  import ascf_pkg::*;
(
  // Clock and reset
  input wire logic        core_clk_in,
  input wire logic        arst_n_in,
  // Measurements and configuration
  input wire logic [15:0] conc_in,
  input wire logic        conc_neg_in,
  input wire logic        over_range_in,
  input wire logic [12:0] ref_mv_in,
  input wire logic [12:0] meas_mv_in,
  input wire logic [11:0] press_cpsi_in,
  input wire logic        low_latch_in,
  input wire logic        high_latch_in,
  input wire logic        cfg_we_in,
  input wire logic [15:0] low_limit_in,
  input wire logic [15:0] high_limit_in,
  input wire logic        panel_clear_key_in,
  // Transmit stream
  input wire logic        tx_ready_in,
  input wire logic        tx_valid_out,
  input wire logic [7:0]  tx_data_out,
  input wire logic        tx_drive_en_out,
  // Indicators
  input wire logic        sensor_ok_led_out,
  input wire logic        invalid_led_out,
  input wire logic        lamp_low_led_out,
  input wire logic        alarm_led_out,
  input wire logic        first_alarm_board_indicator_out,
  input wire logic        second_alarm_board_indicator_out,
  input wire logic [3:0]  status_dout_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] lo_r;
  logic [15:0] up_r;
  logic        llat_r;
  logic        lo_hit;
  logic        up_hit;
  // Shadow of the alarm configuration, loaded like the design's
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lo_r   <= LOW_LIMIT_RST;
      up_r   <= HIGH_LIMIT_RST;
      llat_r <= 1'b1;
    end else if (cfg_we_in) begin
      lo_r   <= low_limit_in;
      up_r   <= high_limit_in;
      llat_r <= low_latch_in;
    end
  end
  // Trigger condition of each level
  assign lo_hit = !conc_neg_in && (conc_in >= lo_r);
  assign up_hit = !conc_neg_in && (conc_in >= up_r);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  low_trig_a: assert property (lo_hit |-> ##2 first_alarm_board_indicator_out)
    else $error("lower indicator missed its trigger");
  high_trig_a: assert property (up_hit |-> ##2 second_alarm_board_indicator_out)
    else $error("upper indicator missed its trigger");
  low_nonlatch_a: assert property (!llat_r && !lo_hit
    |-> ##2 !first_alarm_board_indicator_out)
    else $error("non-latching lower alarm did not drop");
  low_hold_a: assert property (llat_r && $past(llat_r) && first_alarm_board_indicator_out
    && !panel_clear_key_in && !$past(panel_clear_key_in) && !tx_drive_en_out
    |=> first_alarm_board_indicator_out)
    else $error("latched lower alarm dropped without clear");
  high_clear_a: assert property (panel_clear_key_in && !up_hit
    |-> ##2 !second_alarm_board_indicator_out)
    else $error("key press left cleared upper alarm active");
  alarm_led_a: assert property (alarm_led_out
    |-> first_alarm_board_indicator_out
    || second_alarm_board_indicator_out || $past(first_alarm_board_indicator_out)
    || $past(second_alarm_board_indicator_out))
    else $error("alarm led lit with no alarm");
  sensor_ok_a: assert property ($past(arst_n_in) |-> sensor_ok_led_out ==
    $past(!(ref_mv_in > SENSOR_MAX_MV || meas_mv_in > SENSOR_MAX_MV || ref_mv_in < REF_LO_MV)))
    else $error("sensor ok led wrong");
  invalid_a: assert property ($past(arst_n_in) |-> invalid_led_out ==
    $past(conc_neg_in || over_range_in || press_cpsi_in > PRESS_MAX_CPSI))
    else $error("invalid reading led wrong");
  dout_mirror_a: assert property (status_dout_out == {alarm_led_out, lamp_low_led_out,
    invalid_led_out, sensor_ok_led_out})
    else $error("digital status outputs differ from leds");
  tx_stand_a: assert property (tx_valid_out && !tx_ready_in
    |=> tx_valid_out && $stable(tx_data_out))
    else $error("response byte not held");
  tx_drive_a: assert property (tx_valid_out |-> tx_drive_en_out)
    else $error("transmit without driver enable");
endmodule
bind ascf_top ascf_properties u_props (
  .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .conc_in(conc_in),
  .conc_neg_in(conc_neg_in), .over_range_in(over_range_in), .ref_mv_in(ref_mv_in),
  .meas_mv_in(meas_mv_in), .press_cpsi_in(press_cpsi_in), .low_latch_in(low_latch_in),
  .high_latch_in(high_latch_in), .cfg_we_in(cfg_we_in), .low_limit_in(low_limit_in),
  .high_limit_in(high_limit_in), .panel_clear_key_in(panel_clear_key_in),
  .tx_ready_in(tx_ready_in), .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out),
  .tx_drive_en_out(tx_drive_en_out), .sensor_ok_led_out(sensor_ok_led_out),
  .invalid_led_out(invalid_led_out), .lamp_low_led_out(lamp_low_led_out),
  .alarm_led_out(alarm_led_out),
  .first_alarm_board_indicator_out(first_alarm_board_indicator_out),
  .second_alarm_board_indicator_out(second_alarm_board_indicator_out),
  .status_dout_out(status_dout_out));
`default_nettype wire

// File: verification/ascf_host_model.sv
// Host side model: sends framed commands and collects responses
`default_nettype none
module ascf_host_model (
  // Clock
  input  wire logic       core_clk_in,
  // Bytes to the frontend
  output logic            rx_valid_out,
  output logic [7:0]      rx_data_out,
  // Bytes from the frontend
  output logic            tx_ready_out,
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_drive_en_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic         slow;
  logic [127:0] rsp;
  // Idle values
  initial begin
    rx_valid_out = 1'b0;
    rx_data_out  = 8'h00;
    tx_ready_out = 1'b1;
    slow         = 1'b0;
    rsp          = '0;
  end
  // Sink readiness, stalling every other cycle in slow mode
  always @(negedge core_clk_in) tx_ready_out <= slow ? ~tx_ready_out : 1'b1;
  // Shift in each accepted response byte
  always @(posedge core_clk_in) begin
    if (tx_valid_in && tx_ready_out) rsp <= {rsp[119:0], tx_data_in};
  end
  // Send one command once the line is free
  task automatic send(input string s);
    int n;
    n = 0;
    while (tx_drive_en_in && n < 500) begin
      @(negedge core_clk_in);
      n++;
    end
    rsp = '0;
    for (int i = 0; i < s.len(); i++) begin
      @(negedge core_clk_in);
      rx_valid_out = 1'b1;
      rx_data_out  = s[i];
    end
    @(negedge core_clk_in);
    rx_valid_out = 1'b0;
    rx_data_out  = ~rx_data_out; // Stale data is not held
  endtask
endmodule
`default_nettype wire

// File: verification/tb.sv
// Self-checking testbench of the alarm status command frontend
`default_nettype none
module tb;
  import ascf_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, neg, ovr, llat, hlat, cfg_we, key, rx_valid, tx_ready;
  logic        tx_valid, drive_en, s_ok, inval, lamp, alm, ind1, ind2;
  logic [15:0] conc, llim, hlim;
  logic [12:0] ref_mv, meas_mv;
  logic [11:0] press;
  logic [7:0]  rx_data, tx_data;
  logic [3:0]  dout;
  int          error_cnt = 0;
  int          n_tests = 0;
  ascf_top dut (
    .core_clk_in(clk), .arst_n_in(rst_n), .conc_in(conc), .conc_neg_in(neg),
    .over_range_in(ovr), .ref_mv_in(ref_mv), .meas_mv_in(meas_mv), .press_cpsi_in(press),
    .low_latch_in(llat), .high_latch_in(hlat), .cfg_we_in(cfg_we), .low_limit_in(llim),
    .high_limit_in(hlim), .panel_clear_key_in(key), .rx_valid_in(rx_valid),
    .rx_data_in(rx_data), .tx_ready_in(tx_ready), .tx_valid_out(tx_valid),
    .tx_data_out(tx_data), .tx_drive_en_out(drive_en), .sensor_ok_led_out(s_ok),
    .invalid_led_out(inval), .lamp_low_led_out(lamp), .alarm_led_out(alm),
    .first_alarm_board_indicator_out(ind1), .second_alarm_board_indicator_out(ind2),
    .status_dout_out(dout));
  ascf_host_model host (
    .core_clk_in(clk), .rx_valid_out(rx_valid), .rx_data_out(rx_data),
    .tx_ready_out(tx_ready), .tx_valid_in(tx_valid), .tx_data_in(tx_data),
    .tx_drive_en_in(drive_en));
  // Compare one value and count it
  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic finish_test();
    $display("Checks %0d, errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Wait whole cycles at the driving edge
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Apply a concentration and let the indicators settle
  task automatic cset(input logic [15:0] v);
    conc = v;
    tick(3);
  endtask
  // Apply detector readings and judge all three status indicators and the status outputs
  task automatic st(input logic [12:0] r, input logic [12:0] m, input logic [11:0] p,
                    input logic n, input logic o, input logic eok, input logic einv,
                    input logic elamp);
    ref_mv  = r;
    meas_mv = m;
    press   = p;
    neg     = n;
    ovr     = o;
    tick(2);
    check("sensor ok", s_ok, eok);
    check("invalid", inval, einv);
    check("lamp low", lamp, elamp);
    check("status outputs", dout, {1'b0, elamp, einv, eok});
  endtask
  // Send one command and judge the full response
  task automatic cmd(input string s, input logic [127:0] exp);
    host.send(s);
    for (int i = 0; i < 300; i++) begin
      @(negedge clk);
      if (host.rsp[7:0] === CH_CR) break;
    end
    check("response", host.rsp, exp);
    check("driver released", drive_en, 1'b0);
  endtask
  // Status indicator windows at and beyond their bounds
  task automatic t_status();
    st(13'h0bb8, 13'h0bb8, 12'h3e8, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    st(13'h1383, 13'h1383, 12'h5d2, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    st(13'h1384, 13'h0bb8, 12'h3e8, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    st(13'h0bb8, 13'h1384, 12'h3e8, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    st(13'h03e7, 13'h0bb8, 12'h3e8, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    st(13'h03e8, 13'h0bb8, 12'h5d3, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    st(13'h0bb8, 13'h0bb8, 12'h3e8, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    st(13'h0bb8, 13'h0bb8, 12'h3e8, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    st(13'h0bb8, 13'h0bb8, 12'h3e8, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
  endtask
  // Default limits, latching hold and a partial key clear
  task automatic t_alarms();
    cset(16'h0063);
    check("lower off", ind1, 1'b0);
    cset(16'h0064);
    check("lower on", ind1, 1'b1);
    cset(16'h012b);
    check("upper off", ind2, 1'b0);
    cset(16'h012c);
    check("upper on", ind2, 1'b1);
    check("alarm led dark phase", alm, 1'b0);
    cset(16'h0000);
    check("lower held", ind1, 1'b1);
    check("upper held", ind2, 1'b1);
    conc = 16'h00c8;
    key  = 1'b1;
    tick(1);
    key  = 1'b0;
    tick(3);
    check("upper cleared", ind2, 1'b0);
    check("lower kept", ind1, 1'b1);
  endtask
  // Serial query, refused commands and serial clear with a stalling host
  task automatic t_serial();
    cmd({"1ALM", "STAT\r"}, "1:1,0#248\r");
    cset(16'h0000);
    cmd({"1ALM", "ACK#475\r"}, '0);
    check("bad sum no clear", ind1, 1'b1);
    cmd({"2ALM", "ACK\r"}, '0);
    check("other address no clear", ind1, 1'b1);
    host.slow = 1'b1;
    cmd({"1ALM", "ACK#474\r"}, "1:OK#261\r");
    host.slow = 1'b0;
    tick(3);
    check("serial clear", ind1, 1'b0);
    cmd({"1ALM", "STAT\r"}, "1:0,0#247\r");
  endtask
  // Independent per-level mode and limits
  task automatic t_config();
    llat   = 1'b0;
    hlat   = 1'b0;
    llim   = 16'h0032; // Lower limit stays below upper
    hlim   = 16'h003c;
    cfg_we = 1'b1;
    tick(1);
    cfg_we = 1'b0;
    cset(16'h0046);
    check("both on", {ind1, ind2}, 2'b11);
    cset(16'h0037);
    check("upper self clear", {ind1, ind2}, 2'b10);
    cset(16'h000a);
    check("lower self clear", {ind1, ind2}, 2'b00);
    llat   = 1'b1;
    cfg_we = 1'b1;
    tick(1);
    cfg_we = 1'b0;
    cset(16'h0046);
    cset(16'h000a);
    check("mixed modes", {ind1, ind2}, 2'b10);
  endtask
  // Clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Main sequence
  initial begin
    {rst_n, neg, ovr, cfg_we, key} = '0;
    {llat, hlat} = 2'b11;
    conc    = 16'h0000;
    ref_mv  = 13'h0bb8;
    meas_mv = 13'h0bb8;
    press   = 12'h3e8;
    llim    = LOW_LIMIT_RST;
    hlim    = HIGH_LIMIT_RST;
    tick(20);
    rst_n = 1'b1;
    t_status();
    t_alarms();
    t_serial();
    t_config();
    finish_test();
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
endmodule
`default_nettype wire
